// ---- logic/fpdc_copy_engine.sv ----
// Copies the chosen routine from the routine store into on-chip RAM
`timescale 1ns/1ps
module fpdc_copy_engine (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic        prog_sel_i,
  input  wire logic        ers_sel_i,
  input  wire logic [7:0]  dst_i,
  output logic      [7:0]  rom_addr_o,
  input  wire logic [31:0] rom_data_i,
  output logic             ram_we_o,
  output logic      [11:0] ram_addr_o,
  output logic      [31:0] ram_data_o,
  output logic             busy_o,
  output logic             done_o
);

  fpdc_pkg::fpdc_cp_state_type state_ff, nxt_state;
  logic [7:0]  rom_addr_ff;
  logic [3:0]  idx_ff;
  logic [7:0]  dst_ff;
  logic        ram_we_ff;
  logic [11:0] ram_addr_ff;
  logic [31:0] ram_data_ff;

  wire        one_sel  = prog_sel_i ^ ers_sel_i;
  wire [7:0]  rom_base = prog_sel_i ? fpdc_pkg::ROM_PRG_BASE
                                    : fpdc_pkg::ROM_ERS_BASE;
  wire        last     = idx_ff == fpdc_pkg::LAST_WORD;
  wire        go_write = state_ff == fpdc_pkg::CP_WRITE;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fpdc_pkg::CP_IDLE: begin
        if (start_i) begin
          nxt_state = one_sel ? fpdc_pkg::CP_READ
                              : fpdc_pkg::CP_DONE;
        end
      end
      fpdc_pkg::CP_READ:  nxt_state = fpdc_pkg::CP_WRITE;
      fpdc_pkg::CP_WRITE: begin
        nxt_state = last ? fpdc_pkg::CP_DONE : fpdc_pkg::CP_READ;
      end
      fpdc_pkg::CP_DONE:  nxt_state = fpdc_pkg::CP_IDLE;
      default:            nxt_state = fpdc_pkg::CP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff    <= fpdc_pkg::CP_IDLE;
      rom_addr_ff <= fpdc_pkg::RST_BYTE;
      idx_ff      <= 4'h0;
      dst_ff      <= fpdc_pkg::RST_BYTE;
      ram_we_ff   <= 1'b0;
      ram_addr_ff <= 12'h000;
      ram_data_ff <= 32'h0000_0000;
    end else begin
      state_ff  <= nxt_state;
      ram_we_ff <= go_write;
      if (state_ff == fpdc_pkg::CP_IDLE && start_i) begin
        rom_addr_ff <= rom_base;
        idx_ff      <= 4'h0;
        dst_ff      <= dst_i;
      end
      if (go_write) begin
        ram_addr_ff <= {dst_ff, idx_ff};
        ram_data_ff <= rom_data_i;
        idx_ff      <= idx_ff + 4'h1;
        rom_addr_ff <= rom_addr_ff + 8'h01;
      end
    end
  end

  assign rom_addr_o = rom_addr_ff;
  assign ram_we_o   = ram_we_ff;
  assign ram_addr_o = ram_addr_ff;
  assign ram_data_o = ram_data_ff;
  assign busy_o     = state_ff != fpdc_pkg::CP_IDLE;
  assign done_o     = state_ff == fpdc_pkg::CP_DONE;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] wr_cnt_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i || (state_ff == fpdc_pkg::CP_IDLE)) begin
      wr_cnt_ff <= 5'h00;
    end else if (ram_we_ff) begin
      wr_cnt_ff <= wr_cnt_ff + 5'h01;
    end
  end

  property p_all_words;
    @(posedge clk_i) disable iff (srst_i)
    done_o && ram_we_ff |-> wr_cnt_ff == 5'h0F;
  endproperty
  a_all_words: assert property (p_all_words)
    else $error("copy ended before the last word was stored");

  property p_bad_sel;
    @(posedge clk_i) disable iff (srst_i)
    (state_ff == fpdc_pkg::CP_IDLE) && start_i && !one_sel
      |=> done_o && !ram_we_o ##1 !busy_o && !ram_we_o;
  endproperty
  a_bad_sel: assert property (p_bad_sel)
    else $error("invalid selection wrote ram");

endmodule : fpdc_copy_engine

// ---- logic/fpdc_pkg.sv ----
// Constants, types and helpers shared by the download-control block
package fpdc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CCS  = 8'h00;
  localparam logic [7:0] OFS_PRG  = 8'h04;
  localparam logic [7:0] OFS_ERS  = 8'h08;
  localparam logic [7:0] OFS_KEY  = 8'h0C;
  localparam logic [7:0] OFS_DST  = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  // ----------------------------------------------------------------
  // Field positions, values after reset and the copy key
  // ----------------------------------------------------------------
  localparam int         BIT_RELOC = 3;
  localparam int         BIT_REQ   = 0;
  localparam int         BIT_SEL   = 0;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [1:0] RST_RSV   = 2'h0;
  localparam logic [7:0] KEY_COPY  = 8'hA5;

  // ----------------------------------------------------------------
  // Vector regions
  // ----------------------------------------------------------------
  localparam logic [23:0] VEC_LO     = 24'h00_0000;
  localparam logic [23:0] VEC_HI     = 24'h00_007F;
  localparam logic [23:0] RAM_VEC_LO = 24'hFF_E080;
  localparam logic [23:0] RAM_VEC_HI = 24'hFF_E0FF;

  // ----------------------------------------------------------------
  // Routine store layout
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_WORD    = 4'hF;
  localparam logic [7:0] ROM_PRG_BASE = 8'h00;
  localparam logic [7:0] ROM_ERS_BASE = 8'h10;

  typedef enum logic [1:0] {
    CP_IDLE,
    CP_READ,
    CP_WRITE,
    CP_DONE
  } fpdc_cp_state_type;

  function automatic logic fpdc_in_vec(input logic [23:0] a);
    fpdc_in_vec = (a >= VEC_LO) && (a <= VEC_HI);
  endfunction : fpdc_in_vec

endpackage : fpdc_pkg

// ---- logic/fpdc_top.sv ----
// Code control register, copy request guard and AXI4-Lite slave
`timescale 1ns/1ps

// Summary of operation
// - Relocation on: vector fetches go to RAM H'FFE080 to H'FFE0FF.
// - Only vector region H'000000 to H'00007F, vectors up to 31, moves.
// - Relocation off: vector table location is left untouched.
// - Bits 2 and 1 reserved, read/write, reset zero, written as zero.
// - Copy request set copies the selected routine to destination RAM.
// - Request sets only with key H'A5 and code running from RAM.
// - Request bit clears itself when the copy has finished.
// - Request bit is write-only and always reads as zero.
// - Writing zero to the request bit starts no transfer.
// - Program select bit picks program routine; cleared on completion.
// - Erase select bit picks erase routine; cleared on completion.
// - Eight-bit byte registers, cleared by reset and hardware standby.
module fpdc_top (
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        HW_STANDBY_I,
  input  wire logic        EXEC_FROM_RAM_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic      [1:0]  S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic      [31:0] S_AXI_RDATA_O,
  output logic      [1:0]  S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        VEC_FETCH_I,
  input  wire logic [23:0] VEC_ADDR_I,
  output logic      [23:0] VEC_ADDR_O,
  output logic             VEC_RELOCATED_O,
  output logic      [7:0]  ROM_ADDR_O,
  input  wire logic [31:0] ROM_DATA_I,
  output logic             RAM_WE_O,
  output logic      [11:0] RAM_ADDR_O,
  output logic      [31:0] RAM_DATA_O,
  output logic             COPY_BUSY_O
);

  // ----------------------------------------------------------------
  // Reset and standby
  // ----------------------------------------------------------------
  logic stby_s1_ff;
  logic stby_s2_ff;
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      stby_s1_ff <= 1'b0;
      stby_s2_ff <= 1'b0;
    end else begin
      stby_s1_ff <= HW_STANDBY_I;
      stby_s2_ff <= stby_s1_ff;
    end
  end
  wire srst = !RSTN_I || stby_s2_ff;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [7:0]  aw_addr_ff;
  logic [7:0]  w_byte_ff;
  logic        w_lane_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;

  wire aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  wire w_take  = S_AXI_WVALID_I && S_AXI_WREADY_O;
  wire wr_go   = aw_hold_ff && w_hold_ff && !bvalid_ff;
  wire wr_en   = wr_go && w_lane_ff;

  wire wr_ccs  = wr_en && (aw_addr_ff == fpdc_pkg::OFS_CCS);
  wire wr_prg  = wr_en && (aw_addr_ff == fpdc_pkg::OFS_PRG);
  wire wr_ers  = wr_en && (aw_addr_ff == fpdc_pkg::OFS_ERS);
  wire wr_key  = wr_en && (aw_addr_ff == fpdc_pkg::OFS_KEY);
  wire wr_dst  = wr_en && (aw_addr_ff == fpdc_pkg::OFS_DST);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == fpdc_pkg::OFS_CCS) || (a == fpdc_pkg::OFS_PRG) ||
             (a == fpdc_pkg::OFS_ERS) || (a == fpdc_pkg::OFS_KEY) ||
             (a == fpdc_pkg::OFS_DST) || (a == fpdc_pkg::OFS_STAT);
  endfunction : mapped

  assign S_AXI_AWREADY_O = !aw_hold_ff && !bvalid_ff;
  assign S_AXI_WREADY_O  = !w_hold_ff && !bvalid_ff;

  always_ff @(posedge REF_CLK_I) begin
    if (srst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_addr_ff <= fpdc_pkg::RST_BYTE;
      w_byte_ff  <= fpdc_pkg::RST_BYTE;
      w_lane_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'b00;
    end else begin
      if (aw_take) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= S_AXI_AWADDR_I;
      end
      if (w_take) begin
        w_hold_ff <= 1'b1;
        w_byte_ff <= S_AXI_WDATA_I[7:0];
        w_lane_ff <= S_AXI_WSTRB_I[0];
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= mapped(aw_addr_ff) ? 2'b00 : 2'b10;
      end else if (S_AXI_BREADY_I) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign S_AXI_BVALID_O = bvalid_ff;
  assign S_AXI_BRESP_O  = bresp_ff;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic       reloc_ff;
  logic [1:0] rsv_ff;
  logic       req_ff;
  logic       prog_sel_ff;
  logic       ers_sel_ff;
  logic [7:0] key_ff;
  logic [7:0] dst_ff;
  logic       copy_done;

  wire req_set = wr_ccs && w_byte_ff[fpdc_pkg::BIT_REQ] && !req_ff &&
                 (key_ff == fpdc_pkg::KEY_COPY) &&
                 EXEC_FROM_RAM_I;

  always_ff @(posedge REF_CLK_I) begin
    if (srst) begin
      reloc_ff    <= 1'b0;
      rsv_ff      <= fpdc_pkg::RST_RSV;
      req_ff      <= 1'b0;
      prog_sel_ff <= 1'b0;
      ers_sel_ff  <= 1'b0;
      key_ff      <= fpdc_pkg::RST_BYTE;
      dst_ff      <= fpdc_pkg::RST_BYTE;
    end else begin
      if (wr_ccs) begin
        reloc_ff <= w_byte_ff[fpdc_pkg::BIT_RELOC];
        rsv_ff   <= w_byte_ff[2:1];
      end
      if (req_set) begin
        req_ff <= 1'b1;
      end else if (copy_done) begin
        req_ff <= 1'b0;
      end
      if (wr_prg) begin
        prog_sel_ff <= w_byte_ff[fpdc_pkg::BIT_SEL];
      end else if (copy_done) begin
        prog_sel_ff <= 1'b0;
      end
      if (wr_ers) begin
        ers_sel_ff <= w_byte_ff[fpdc_pkg::BIT_SEL];
      end else if (copy_done) begin
        ers_sel_ff <= 1'b0;
      end
      if (wr_key) begin
        key_ff <= w_byte_ff;
      end
      if (wr_dst) begin
        dst_ff <= w_byte_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  wire       ar_take  = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire [7:0] ccs_view = {4'h0, reloc_ff, rsv_ff, 1'b0};
  wire [7:0] rd_byte  =
    (S_AXI_ARADDR_I == fpdc_pkg::OFS_CCS)  ? ccs_view :
    (S_AXI_ARADDR_I == fpdc_pkg::OFS_PRG)  ? {7'h00, prog_sel_ff} :
    (S_AXI_ARADDR_I == fpdc_pkg::OFS_ERS)  ? {7'h00, ers_sel_ff} :
    (S_AXI_ARADDR_I == fpdc_pkg::OFS_KEY)  ? key_ff :
    (S_AXI_ARADDR_I == fpdc_pkg::OFS_DST)  ? dst_ff :
    (S_AXI_ARADDR_I == fpdc_pkg::OFS_STAT) ? {7'h00, COPY_BUSY_O} :
                                             fpdc_pkg::RST_BYTE;

  assign S_AXI_ARREADY_O = !rvalid_ff;

  always_ff @(posedge REF_CLK_I) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= 2'b00;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, rd_byte};
      rresp_ff  <= mapped(S_AXI_ARADDR_I) ? 2'b00 : 2'b10;
    end else if (S_AXI_RREADY_I) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign S_AXI_RVALID_O = rvalid_ff;
  assign S_AXI_RDATA_O  = rdata_ff;
  assign S_AXI_RRESP_O  = rresp_ff;

  // ----------------------------------------------------------------
  // Vector relocation and routine copy
  // ----------------------------------------------------------------
  fpdc_vec_remap u_remap (
    .clk_i        (REF_CLK_I),
    .srst_i       (srst),
    .reloc_i      (reloc_ff),
    .fetch_i      (VEC_FETCH_I),
    .addr_i       (VEC_ADDR_I),
    .addr_o       (VEC_ADDR_O),
    .redirected_o (VEC_RELOCATED_O)
  );

  fpdc_copy_engine u_copy (
    .clk_i      (REF_CLK_I),
    .srst_i     (srst),
    .start_i    (req_set),
    .prog_sel_i (prog_sel_ff),
    .ers_sel_i  (ers_sel_ff),
    .dst_i      (dst_ff),
    .rom_addr_o (ROM_ADDR_O),
    .rom_data_i (ROM_DATA_I),
    .ram_we_o   (RAM_WE_O),
    .ram_addr_o (RAM_ADDR_O),
    .ram_data_o (RAM_DATA_O),
    .busy_o     (COPY_BUSY_O),
    .done_o     (copy_done)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_req_guard;
    @(posedge REF_CLK_I) disable iff (srst)
    $rose(req_ff) |-> $past(key_ff) == fpdc_pkg::KEY_COPY &&
                      $past(EXEC_FROM_RAM_I) && $past(wr_ccs);
  endproperty
  a_req_guard: assert property (p_req_guard)
    else $error("copy request set without key or ram execution");

  property p_zero_no_start;
    @(posedge REF_CLK_I) disable iff (srst)
    wr_ccs && !w_byte_ff[0] && !req_ff |=> !req_ff && !COPY_BUSY_O;
  endproperty
  a_zero_no_start: assert property (p_zero_no_start)
    else $error("writing zero started a copy");

  property p_start_copy;
    @(posedge REF_CLK_I) disable iff (srst)
    req_set |=> COPY_BUSY_O && req_ff;
  endproperty
  a_start_copy: assert property (p_start_copy)
    else $error("accepted request did not start the copy");

  property p_clear_done;
    @(posedge REF_CLK_I) disable iff (srst)
    copy_done |=> !req_ff ##1 !COPY_BUSY_O;
  endproperty
  a_clear_done: assert property (p_clear_done)
    else $error("request bit not cleared after copy");

  property p_read_zero;
    @(posedge REF_CLK_I) disable iff (srst)
    ar_take && S_AXI_ARADDR_I == fpdc_pkg::OFS_CCS |=> !S_AXI_RDATA_O[0];
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("copy request bit read as one");

  property p_prg_clear;
    @(posedge REF_CLK_I) disable iff (srst)
    copy_done && !wr_prg |=> !prog_sel_ff;
  endproperty
  a_prg_clear: assert property (p_prg_clear)
    else $error("program select kept after copy");

  property p_ers_clear;
    @(posedge REF_CLK_I) disable iff (srst)
    copy_done && !wr_ers |=> !ers_sel_ff;
  endproperty
  a_ers_clear: assert property (p_ers_clear)
    else $error("erase select kept after copy");

  property p_reset_clear;
    @(posedge REF_CLK_I)
    $past(srst) |-> rsv_ff == fpdc_pkg::RST_RSV && !reloc_ff &&
                    !req_ff && key_ff == fpdc_pkg::RST_BYTE;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control register not cleared by reset");

  c_copy_run: cover property (@(posedge REF_CLK_I) disable iff (srst)
    req_set ##[1:60] copy_done);
  c_reloc_fetch: cover property (@(posedge REF_CLK_I) disable iff (srst)
    VEC_RELOCATED_O);
  c_key_refused: cover property (@(posedge REF_CLK_I) disable iff (srst)
    wr_ccs && w_byte_ff[0] && key_ff != fpdc_pkg::KEY_COPY);

endmodule : fpdc_top

// ---- logic/fpdc_vec_remap.sv ----
// Interrupt vector fetch address relocation
`timescale 1ns/1ps
module fpdc_vec_remap (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        reloc_i,
  input  wire logic        fetch_i,
  input  wire logic [23:0] addr_i,
  output logic      [23:0] addr_o,
  output logic             redirected_o
);

  logic [23:0] addr_ff;
  logic        redir_ff;
  wire         hit      = reloc_i && fetch_i && fpdc_pkg::fpdc_in_vec(addr_i);
  wire  [23:0] ram_addr = fpdc_pkg::RAM_VEC_LO | {17'h0_0000, addr_i[6:0]};
  wire  [23:0] nxt_addr = hit ? ram_addr : addr_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      addr_ff  <= fpdc_pkg::VEC_LO;
      redir_ff <= 1'b0;
    end else begin
      addr_ff  <= nxt_addr;
      redir_ff <= hit;
    end
  end

  assign addr_o       = addr_ff;
  assign redirected_o = redir_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reloc_ram;
    @(posedge clk_i) disable iff (srst_i)
    hit |=> addr_o >= fpdc_pkg::RAM_VEC_LO &&
            addr_o <= fpdc_pkg::RAM_VEC_HI &&
            addr_o[6:0] == $past(addr_i[6:0]);
  endproperty
  a_reloc_ram: assert property (p_reloc_ram)
    else $error("relocated vector outside ram table");

  property p_reloc_only_low;
    @(posedge clk_i) disable iff (srst_i)
    !fpdc_pkg::fpdc_in_vec(addr_i) |=> addr_o == $past(addr_i);
  endproperty
  a_reloc_only_low: assert property (p_reloc_only_low)
    else $error("address outside vector region was altered");

  property p_no_reloc;
    @(posedge clk_i) disable iff (srst_i)
    !reloc_i |=> addr_o == $past(addr_i) && !redirected_o;
  endproperty
  a_no_reloc: assert property (p_no_reloc)
    else $error("vector moved while relocation off");

endmodule : fpdc_vec_remap

// ---- tb/fpdc_bench.sv ----
// Self-checking bench for the download-control block
`timescale 1ns/1ps
module fpdc_bench;
  typedef struct packed {
    logic        rel;
    logic [23:0] a;
    logic [23:0] e;
    logic        r;
  } fpdc_vrow_type;
  logic        clk, rstn, stby, exec_ram, awv, wv, bre, arv, rre, fetch;
  logic        awr, wr_o, bv, arr, rv, rel_o, we, busy;
  logic [7:0]  awa, ara, rom_a;
  logic [31:0] wd, rd, rom_d, ram_d;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  logic [23:0] va, va_o;
  logic [11:0] ram_a;
  logic [7:0]  exp_dst, exp_base;
  logic [31:0] got;
  logic [1:0]  resp;
  int          failures, tests_run, we_cnt, i;
  fpdc_vrow_type rows [5];

  fpdc_top u_fpdc_top (.REF_CLK_I(clk), .RSTN_I(rstn), .HW_STANDBY_I(stby),
    .EXEC_FROM_RAM_I(exec_ram), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_o), .S_AXI_BRESP_O(br),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre),
    .VEC_FETCH_I(fetch), .VEC_ADDR_I(va), .VEC_ADDR_O(va_o),
    .VEC_RELOCATED_O(rel_o), .ROM_ADDR_O(rom_a), .ROM_DATA_I(rom_d),
    .RAM_WE_O(we), .RAM_ADDR_O(ram_a), .RAM_DATA_O(ram_d),
    .COPY_BUSY_O(busy));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Routine store model: one clock of latency
  always_ff @(posedge clk) rom_d <= {8'hC0, 16'h0000, rom_a};

  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Each stored word lands at its index behind the destination
  always @(posedge clk) if (we === 1'b1) begin
    chk("ram_addr", {20'h0_0000, ram_a}, {20'h0_0000, exp_dst, we_cnt[3:0]});
    chk("ram_data", ram_d, {8'hC0, 16'h0000, exp_base + we_cnt[7:0]});
    we_cnt++;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awa <= a; wd <= {24'h00_0000, d}; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awr) begin aw_ok = 1'b1; awv <= 1'b0; end
      if (!w_ok && wr_o) begin w_ok = 1'b1; wv <= 1'b0; end
    end
    do @(posedge clk); while (bv !== 1'b1);
    resp = br;
    bre <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk);
    got = rd;
    resp = rr;
    rre <= 1'b0;
    @(posedge clk);
  endtask : rdr

  task automatic copy(input logic p, input logic q, input int n);
    we_cnt = 0;
    fetch <= 1'b0;
    exp_dst = 8'h3C;
    exp_base = p ? fpdc_pkg::ROM_PRG_BASE : fpdc_pkg::ROM_ERS_BASE;
    wr(fpdc_pkg::OFS_KEY, fpdc_pkg::KEY_COPY);
    wr(fpdc_pkg::OFS_DST, exp_dst);
    wr(fpdc_pkg::OFS_PRG, {7'h00, p});
    wr(fpdc_pkg::OFS_ERS, {7'h00, q});
    wr(fpdc_pkg::OFS_CCS, 8'h01);
    repeat (4) @(posedge clk);
    rdr(fpdc_pkg::OFS_CCS);
    chk("request_read", got, 32'h0000_0000);
    for (i = 0; i < 100 && busy; i++) @(posedge clk);
    chk("words", we_cnt, n);
    chk("request", {31'h0, u_fpdc_top.req_ff}, 32'h0000_0000);
    if (n != 0) begin
      rdr(fpdc_pkg::OFS_PRG);
      chk("prog_sel", got, 32'h0000_0000);
      rdr(fpdc_pkg::OFS_ERS);
      chk("ers_sel", got, 32'h0000_0000);
    end
    $display("copy test %0d%0d done", p, q);
  endtask : copy

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0; stby = 1'b0; exec_ram = 1'b1; awv = 1'b0; wv = 1'b0;
    bre = 1'b0; arv = 1'b0; rre = 1'b0; fetch = 1'b0; awa = 8'h00;
    ara = 8'h00; wd = 32'h0000_0000; ws = 4'hF; va = 24'h00_0000;
    failures = 0; tests_run = 0; we_cnt = 0; exp_dst = 8'h00;
    exp_base = 8'h00;
    rows[0] = {1'b0, 24'h00_0045, 24'h00_0045, 1'b0};
    rows[1] = {1'b1, 24'h00_0045, 24'hFF_E0C5, 1'b1};
    rows[2] = {1'b1, 24'h00_007F, 24'hFF_E0FF, 1'b1};
    rows[3] = {1'b1, 24'h00_0080, 24'h00_0080, 1'b0};
    rows[4] = {1'b1, 24'h00_0000, 24'hFF_E080, 1'b1};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 5; i++) begin
      wr(fpdc_pkg::OFS_CCS, {4'h0, rows[i].rel, 3'h0});
      fetch <= 1'b1;
      va <= rows[i].a;
      @(posedge clk);
      fetch <= 1'b0;
      @(posedge clk);
      chk("vec_addr", {8'h00, va_o}, {8'h00, rows[i].e});
      chk("vec_flag", {31'h0, rel_o}, {31'h0, rows[i].r});
    end
    $display("vector table done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i <= 5; i++) begin
      rdr(8'(4 * i));
      chk("reset_value", got, 32'h0000_0000);
    end
    rdr(8'h18);
    chk("unmapped", {30'h0, resp}, 32'h0000_0002);
    wr(fpdc_pkg::OFS_CCS, 8'h06);
    chk("wr_resp", {30'h0, resp}, 32'h0000_0000);
    rdr(fpdc_pkg::OFS_CCS);
    chk("reserved_rw", got, 32'h0000_0006);
    wr(fpdc_pkg::OFS_CCS, 8'h00);
    $display("register test done");
    copy(1'b1, 1'b0, 16);
    copy(1'b0, 1'b1, 16);
    copy(1'b1, 1'b1, 0);
    copy(1'b0, 1'b0, 0);
    for (i = 0; i < 3; i++) begin
      we_cnt = 0;
      wr(fpdc_pkg::OFS_PRG, 8'h01);
      wr(fpdc_pkg::OFS_KEY, i == 0 ? 8'h5A : 8'hA5);
      exec_ram <= (i != 1);
      wr(fpdc_pkg::OFS_CCS, i == 2 ? 8'h00 : 8'h01);
      chk("refused_busy", {31'h0, busy}, 32'h0000_0000);
      repeat (40) @(posedge clk);
      chk("refused_words", we_cnt, 0);
      exec_ram <= 1'b1;
    end
    $display("refusal test done");
    wr(fpdc_pkg::OFS_KEY, 8'hA5);
    stby <= 1'b1;
    repeat (4) @(posedge clk);
    stby <= 1'b0;
    repeat (2) @(posedge clk);
    rdr(fpdc_pkg::OFS_KEY);
    chk("standby_clear", got, 32'h0000_0000);
    $display("standby test done");
    end_of_test;
  end
endmodule : fpdc_bench
